// ---- l2pc_cfg.svh ----
// constants of the cache power, scratch region and ecc control block
//
// Notes on behaviour
// - four-bit power-down register at 0x174
// - bank is thirty-two 2048x64 macros, 512 KB
// - stored word is 72 bits, 8 check bits
// - bit n powers off macros 8n to 8n+7
// - capacity selectable by shutting down macro groups
// - unbacked region allocates into enabled unmasked ways
// - evicted unbacked lines are dropped, no writeback
// - unbacked region is cacheable in first-level caches
// - secded on data and on tag metadata
// - single injection by software, double internal only
// - correctable error fixed and written back at once
// - last corrected address kept, metadata and data
// - each correction raises its event and counts, the count saturating at all ones
// - four error event outputs to interrupt controller
// - event cleared by reading its count register
// - masks limit allocation only, reads hit all
// - way limit resets to 0, only increases
`ifndef L2PC_CFG_SVH
`define L2PC_CFG_SVH
`define L2PC_OFF_CFG 12'h000
`define L2PC_OFF_WAYLIM 12'h008
`define L2PC_OFF_INJ 12'h040
`define L2PC_OFF_TRK 12'h100
`define L2PC_TRK_STRIDE 12'h020
`define L2PC_TRK_AHI 12'h004
`define L2PC_TRK_CNT 12'h008
`define L2PC_OFF_PD 12'h174
`define L2PC_OFF_MASK 12'h800
`define L2PC_MASK_STRIDE 12'h008
`define L2PC_NUM_MASTERS 15
`define L2PC_NUM_WAYS 16
`define L2PC_NUM_TRK 4
`define L2PC_NUM_MACROS 32
`define L2PC_MACROS_PER_GRP 8
`define L2PC_ECC_W 72
`define L2PC_ECC_CHK 7
`define L2PC_INJ_EN_BIT 16
`define L2PC_PD_RST 4'h0
`define L2PC_WAYLIM_RST 8'h00
`define L2PC_CFG_BANKS 8'h04
`define L2PC_CFG_SETS 8'h09
`define L2PC_CFG_BYTES 8'h06
`define L2PC_FULL_KB 12'h800
`define L2PC_GRP_KB 12'h200
`define L2PC_CNT_MAX 32'hFFFF_FFFF
`define L2PC_SCR_BASE 64'h0000_0000_0A00_0000
`define L2PC_SCR_MASK 64'h0000_0000_001F_FFFF
`define L2PC_RESP_OK 2'h0
`define L2PC_RESP_ERR 2'h2
`endif

// ---- l2pc_ctrl.sv ----
// cache power-down, unbacked allocation region and ecc tracking control
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "l2pc_cfg.svh"
module l2pc_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic [31:0] ram_macro_power_en,
    output logic [11:0] cache_capacity_kb,
    output logic [15:0] cache_way_usable,
    input wire logic alloc_req,
    input wire logic [3:0] alloc_master,
    input wire logic [63:0] alloc_addr,
    input wire logic alloc_mem_cacheable,
    output logic alloc_valid,
    output logic alloc_none,
    output logic [3:0] alloc_way,
    output logic alloc_cacheable,
    output logic alloc_unbacked,
    input wire logic evict_req,
    input wire logic evict_dirty,
    input wire logic [63:0] evict_addr,
    output logic evict_writeback,
    input wire logic enc_req,
    input wire logic [63:0] enc_data,
    input wire logic enc_dbl_inject,
    output logic enc_valid,
    output logic [71:0] enc_word,
    input wire logic chk_req,
    input wire logic chk_meta,
    input wire logic [63:0] chk_addr,
    input wire logic [71:0] chk_word,
    output logic chk_valid,
    output logic chk_fail,
    output logic [63:0] chk_data,
    output logic wb_valid,
    output logic [63:0] wb_addr,
    output logic [71:0] wb_word,
    output logic meta_corrected_event,
    output logic meta_uncorrectable_event,
    output logic data_corrected_event,
    output logic data_uncorrectable_event
);
    l2pc_pkg::l2pc_ctrl_st_t st_q;
    l2pc_pkg::l2pc_ctrl_st_t st_d;
    logic [71:0] enc_raw;
    logic [71:0] fixed_w;
    logic [63:0] fixed_d;
    logic single_c;
    logic double_c;
    logic [3:0] trk_evt;
    logic [3:0] trk_rdclr;
    logic [3:0] trk_flag;
    logic [63:0] trk_addr [4];
    logic [31:0] trk_cnt [4];

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[8*b +: 8] = d[8*b +: 8];
        end
        return r;
    endfunction : wmerge

    function automatic logic [11:0] trk_off(input int t, input logic [11:0] sub);
        return 12'(`L2PC_OFF_TRK + t * `L2PC_TRK_STRIDE + sub);
    endfunction : trk_off

    function automatic logic [11:0] mask_off(input int m);
        return 12'(`L2PC_OFF_MASK + m * `L2PC_MASK_STRIDE);
    endfunction : mask_off

    function automatic logic mapped(input logic [11:0] a);
        logic r;
        r = (a == `L2PC_OFF_CFG) || (a == `L2PC_OFF_WAYLIM) || (a == `L2PC_OFF_INJ)
            || (a == `L2PC_OFF_PD);
        for (int t = 0; t < `L2PC_NUM_TRK; t++) begin
            if (a == trk_off(t, 12'h000) || a == trk_off(t, `L2PC_TRK_AHI)
                || a == trk_off(t, `L2PC_TRK_CNT)) r = 1'b1;
        end
        for (int m = 0; m < `L2PC_NUM_MASTERS; m++) begin
            if (a == mask_off(m) || a == 12'(mask_off(m) + 12'h004)) r = 1'b1;
        end
        return r;
    endfunction : mapped

    function automatic logic in_scr(input logic [63:0] a);
        return (a & ~`L2PC_SCR_MASK) == `L2PC_SCR_BASE;
    endfunction : in_scr

    // ----------------------------------------------------------------
    // ecc and error trackers
    // ----------------------------------------------------------------
    l2pc_secded u_secded (
        .enc_data(enc_data),
        .enc_word(enc_raw),
        .chk_word(chk_word),
        .chk_fixed(fixed_w),
        .chk_data(fixed_d),
        .chk_single(single_c),
        .chk_double(double_c)
    );

    assign trk_evt[l2pc_pkg::L2PC_META_FIX] = chk_req && chk_meta && single_c;
    assign trk_evt[l2pc_pkg::L2PC_META_FAIL] = chk_req && chk_meta && double_c;
    assign trk_evt[l2pc_pkg::L2PC_DATA_FIX] = chk_req && !chk_meta && single_c;
    assign trk_evt[l2pc_pkg::L2PC_DATA_FAIL] = chk_req && !chk_meta && double_c;

    l2pc_trk_if trk_if [4] ();

    for (genvar g = 0; g < `L2PC_NUM_TRK; g++) begin : g_trk
        assign trk_if[g].evt = trk_evt[g];
        assign trk_if[g].addr = chk_addr;
        assign trk_if[g].rd_clr = trk_rdclr[g];
        assign trk_addr[g] = trk_if[g].cap_addr;
        assign trk_cnt[g] = trk_if[g].count;
        assign trk_flag[g] = trk_if[g].flag;
        l2pc_err_track u_trk (
            .aclk(aclk),
            .aresetn(aresetn),
            .trk(trk_if[g])
        );
    end

    // count reads clear their event
    always_comb begin
        for (int t = 0; t < `L2PC_NUM_TRK; t++) begin
            trk_rdclr[t] = arvalid && arready && (araddr == trk_off(t, `L2PC_TRK_CNT));
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] wv;
        logic [31:0] rv;
        logic [15:0] mm;
        st_d = st_q;
        wv = '0;
        rv = '0;
        mm = '1;
        if (awvalid && awready) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            st_d.w_have = 1'b1;
            st_d.w_data = wdata;
            st_d.w_strb = wstrb;
        end
        if (st_q.bvalid && bready) st_d.bvalid = 1'b0;
        // one-shot injection is spent on the next encoded write
        if (enc_req && st_q.inj_en) st_d.inj_en = 1'b0;
        if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = mapped(st_q.aw_addr) ? `L2PC_RESP_OK : `L2PC_RESP_ERR;
            case (st_q.aw_addr)
                `L2PC_OFF_PD: begin
                    wv = wmerge({28'h0, st_q.pd}, st_q.w_data, st_q.w_strb);
                    st_d.pd = wv[3:0];
                end
                `L2PC_OFF_WAYLIM: begin
                    wv = wmerge({24'h0, st_q.way_lim}, st_q.w_data, st_q.w_strb);
                    if (wv[7:0] > st_q.way_lim) st_d.way_lim = wv[7:0];
                end
                `L2PC_OFF_INJ: begin
                    wv = wmerge({15'h0, st_q.inj_en, 9'h0, st_q.inj_bit}, st_q.w_data,
                                st_q.w_strb);
                    st_d.inj_en = wv[`L2PC_INJ_EN_BIT];
                    st_d.inj_bit = wv[6:0];
                end
                default: begin
                    for (int m = 0; m < `L2PC_NUM_MASTERS; m++) begin
                        if (st_q.aw_addr == mask_off(m)) begin
                            wv = wmerge({16'h0, st_q.mask[m]}, st_q.w_data, st_q.w_strb);
                            st_d.mask[m] = wv[15:0];
                        end
                    end
                end
            endcase
        end
        if (st_q.rvalid && rready) st_d.rvalid = 1'b0;
        if (arvalid && arready) begin
            case (araddr)
                `L2PC_OFF_CFG: rv = {`L2PC_CFG_BYTES, `L2PC_CFG_SETS,
                                     8'(st_q.way_lim + 8'h01), `L2PC_CFG_BANKS};
                `L2PC_OFF_WAYLIM: rv = {24'h0, st_q.way_lim};
                `L2PC_OFF_INJ: rv = {15'h0, st_q.inj_en, 9'h0, st_q.inj_bit};
                `L2PC_OFF_PD: rv = {28'h0, st_q.pd};
                default: begin
                    for (int t = 0; t < `L2PC_NUM_TRK; t++) begin
                        if (araddr == trk_off(t, 12'h000)) rv = trk_addr[t][31:0];
                        if (araddr == trk_off(t, `L2PC_TRK_AHI)) rv = trk_addr[t][63:32];
                        if (araddr == trk_off(t, `L2PC_TRK_CNT)) rv = trk_cnt[t];
                    end
                    for (int m = 0; m < `L2PC_NUM_MASTERS; m++) begin
                        if (araddr == mask_off(m)) rv = {16'h0, st_q.mask[m]};
                    end
                end
            endcase
            st_d.rvalid = 1'b1;
            st_d.rdata = rv;
            st_d.rresp = mapped(araddr) ? `L2PC_RESP_OK : `L2PC_RESP_ERR;
        end

        // ------------------------------------------------------------
        // allocation and eviction
        // ------------------------------------------------------------
        st_d.alloc_valid = alloc_req;
        st_d.alloc_none = 1'b1;
        st_d.alloc_way = '0;
        if (alloc_master < 4'(`L2PC_NUM_MASTERS)) mm = st_q.mask[alloc_master];
        for (int w = `L2PC_NUM_WAYS - 1; w >= 0; w--) begin
            if (8'(w) <= st_q.way_lim && !mm[w]) begin
                st_d.alloc_none = 1'b0;
                st_d.alloc_way = 4'(w);
            end
        end
        st_d.alloc_unbacked = in_scr(alloc_addr);
        st_d.alloc_cacheable = in_scr(alloc_addr) || alloc_mem_cacheable;
        st_d.evict_writeback = evict_req && evict_dirty && !in_scr(evict_addr);

        // ------------------------------------------------------------
        // ecc datapath
        // ------------------------------------------------------------
        st_d.enc_valid = enc_req;
        st_d.enc_word = enc_raw;
        if (st_q.inj_en && st_q.inj_bit < 7'(`L2PC_ECC_W)) begin
            st_d.enc_word[st_q.inj_bit] = !enc_raw[st_q.inj_bit];
        end
        if (enc_dbl_inject) st_d.enc_word[1:0] = ~st_d.enc_word[1:0];
        st_d.chk_valid = chk_req;
        st_d.chk_fail = chk_req && double_c;
        st_d.chk_data = fixed_d;
        st_d.wb_valid = chk_req && single_c;
        st_d.wb_word = fixed_w;
        st_d.wb_addr = chk_addr;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.pd <= `L2PC_PD_RST;
            st_q.way_lim <= `L2PC_WAYLIM_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign awready = !st_q.aw_have && !st_q.bvalid;
    assign wready = !st_q.w_have && !st_q.bvalid;
    assign bvalid = st_q.bvalid;
    assign bresp = st_q.bresp;
    assign arready = !st_q.rvalid;
    assign rvalid = st_q.rvalid;
    assign rdata = st_q.rdata;
    assign rresp = st_q.rresp;

    // one enable per macro position, shared by all four banks
    always_comb begin
        cache_capacity_kb = `L2PC_FULL_KB;
        for (int m = 0; m < `L2PC_NUM_MACROS; m++) begin
            ram_macro_power_en[m] = !st_q.pd[m / `L2PC_MACROS_PER_GRP];
        end
        for (int n = 0; n < 4; n++) begin
            if (st_q.pd[n]) cache_capacity_kb = cache_capacity_kb - `L2PC_GRP_KB;
        end
        for (int w = 0; w < `L2PC_NUM_WAYS; w++) begin
            cache_way_usable[w] = 8'(w) <= st_q.way_lim;
        end
    end

    assign alloc_valid = st_q.alloc_valid;
    assign alloc_none = st_q.alloc_none;
    assign alloc_way = st_q.alloc_way;
    assign alloc_cacheable = st_q.alloc_cacheable;
    assign alloc_unbacked = st_q.alloc_unbacked;
    assign evict_writeback = st_q.evict_writeback;
    assign enc_valid = st_q.enc_valid;
    assign enc_word = st_q.enc_word;
    assign chk_valid = st_q.chk_valid;
    assign chk_fail = st_q.chk_fail;
    assign chk_data = st_q.chk_data;
    assign wb_valid = st_q.wb_valid;
    assign wb_addr = st_q.wb_addr;
    assign wb_word = st_q.wb_word;
    assign meta_corrected_event = trk_flag[l2pc_pkg::L2PC_META_FIX];
    assign meta_uncorrectable_event = trk_flag[l2pc_pkg::L2PC_META_FAIL];
    assign data_corrected_event = trk_flag[l2pc_pkg::L2PC_DATA_FIX];
    assign data_uncorrectable_event = trk_flag[l2pc_pkg::L2PC_DATA_FAIL];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_pd_write;
        (awvalid && awready && wvalid && wready && awaddr == `L2PC_OFF_PD && wstrb[0])
            |-> ##2 (ram_macro_power_en[7:0] == {8{!$past(wdata[0], 2)}}
                 && ram_macro_power_en[31:24] == {8{!$past(wdata[3], 2)}} && bvalid);
    endproperty
    a_pd_write: assert property (p_pd_write) else $error("power-down write not applied");

    property p_pd_reset;
        $rose(aresetn) |-> (ram_macro_power_en == '1 && cache_capacity_kb == `L2PC_FULL_KB);
    endproperty
    a_pd_reset: assert property (p_pd_reset) else $error("macros not powered after reset");

    property p_waylim_mono;
        ##1 (st_q.way_lim >= $past(st_q.way_lim));
    endproperty
    a_waylim_mono: assert property (p_waylim_mono) else $error("way limit decreased");

    property p_alloc_ok;
        alloc_req |=> (alloc_valid && (alloc_none || 8'(alloc_way) <= st_q.way_lim));
    endproperty
    a_alloc_ok: assert property (p_alloc_ok) else $error("allocation into disabled way");

    property p_evict_drop;
        (evict_req && in_scr(evict_addr)) |=> !evict_writeback;
    endproperty
    a_evict_drop: assert property (p_evict_drop) else $error("unbacked line written back");

    property p_fix_wb;
        (chk_req && single_c) |=> (wb_valid && wb_word == $past(fixed_w)
                                  && wb_addr == $past(chk_addr));
    endproperty
    a_fix_wb: assert property (p_fix_wb) else $error("corrected word not written back");

    property p_fail_no_wb;
        (chk_req && double_c) |=> (!wb_valid && chk_fail);
    endproperty
    a_fail_no_wb: assert property (p_fail_no_wb) else $error("double error mishandled");

    property p_event_raise;
        (chk_req && single_c) |=> ($past(chk_meta) ? meta_corrected_event : data_corrected_event);
    endproperty
    a_event_raise: assert property (p_event_raise) else $error("fix event not raised");

    property p_b_hold;
        (bvalid && !bready) |=> (bvalid && $stable(bresp));
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
endmodule : l2pc_ctrl

// ---- l2pc_ctrl_tb_top.sv ----
// self-checking bench of the cache power, scratch and ecc control block
`timescale 1ns/1ps
module l2pc_ctrl_tb_top;
    // ----
    // signals and instances
    // ----
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0, cache_capacity_kb;
    logic [31:0] wdata = 0, rdata, ram_macro_power_en, rv, pe;
    logic [3:0] wstrb = 4'hF, alloc_way, req, master;
    logic awready, wready, bvalid, arready, rvalid, alloc_valid, alloc_none, alloc_cacheable;
    logic alloc_unbacked, evict_writeback, enc_valid, chk_valid, chk_fail, wb_valid, meta;
    logic meta_corrected_event, meta_uncorrectable_event, data_corrected_event;
    logic data_uncorrectable_event;
    logic [1:0] bresp, rresp, rr;
    logic [15:0] cache_way_usable;
    logic [63:0] chk_data, wb_addr, addr;
    logic [71:0] enc_word, wb_word, data, w;
    logic [15:0] rows [4] = '{16'h1600, 16'h3400, 16'h7200, 16'h0800};
    wire [3:0] evt = {meta_corrected_event, meta_uncorrectable_event, data_corrected_event,
                      data_uncorrectable_event};
    int miscompares = 0, cmp_count = 0, i, m;
    always #2.5 aclk = ~aclk;
    l2pc_master_model mdl (.aclk, .req, .meta, .master, .addr, .data);
    l2pc_ctrl uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
        .rresp, .ram_macro_power_en, .cache_capacity_kb, .cache_way_usable,
        .alloc_req(req[0]), .alloc_master(master), .alloc_addr(addr), .alloc_mem_cacheable(1'h0),
        .alloc_valid, .alloc_none, .alloc_way, .alloc_cacheable, .alloc_unbacked,
        .evict_req(req[1]), .evict_dirty(1'h1), .evict_addr(addr), .evict_writeback,
        .enc_req(req[2]), .enc_data(data[63:0]), .enc_dbl_inject(1'h0), .enc_valid, .enc_word,
        .chk_req(req[3]), .chk_meta(meta), .chk_addr(addr), .chk_word(data), .chk_valid,
        .chk_fail, .chk_data, .wb_valid, .wb_addr, .wb_word, .meta_corrected_event,
        .meta_uncorrectable_event, .data_corrected_event, .data_uncorrectable_event);
    // ----
    // bus cycles, compare and verdict
    // ----
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (tb) break;
        end
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        logic ta, tb;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(negedge aclk);
            ta = arvalid && arready;
            tb = rvalid;
            rv = rdata;
            rr = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'h0;
            if (tb) break;
        end
        rready <= 1'h0;
    endtask : rd
    task automatic cmp(input string n, input logic [71:0] e, input logic [71:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3000) @(posedge aclk);
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        cmp("pwr", 32'hFFFF_FFFF, ram_macro_power_en);
        cmp("ways", 16'h0001, cache_way_usable);
        for (i = 0; i < 4; i++) begin
            wr(12'h174, {28'h0, rows[i][15:12]});
            @(negedge aclk);
            for (m = 0; m < 32; m++) pe[m] = !rows[i][12 + m / 8];
            cmp("pwr", pe, ram_macro_power_en);
            cmp("kb", rows[i][11:0], cache_capacity_kb);
            rd(12'h174);
            cmp("pd", rows[i][15:12], rv);
        end
        rd(12'h300);
        cmp("unmapped", 34'h2_0000_0000, {rr, rv});
        wr(12'h008, 32'h3);
        wr(12'h008, 32'h1);
        rd(12'h000);
        cmp("cfg", 32'h0609_0404, rv);
        cmp("ways", 16'h000F, cache_way_usable);
        wr(12'h810, 32'hFFF9);
        mdl.send(4'h1, 1'h0, 4'h2, 64'h0A00_0040, 72'h0);
        cmp("alloc", 8'h87, {alloc_valid, alloc_none, alloc_way, alloc_cacheable, alloc_unbacked});
        mdl.send(4'h2, 1'h0, 4'h0, 64'h0A00_0040, 72'h0);
        cmp("wback", 1'h0, evict_writeback);
        mdl.send(4'h2, 1'h0, 4'h0, 64'h8000_0000, 72'h0);
        cmp("wback", 1'h1, evict_writeback);
        wr(12'h810, 32'hFFFF);
        mdl.send(4'h1, 1'h0, 4'h2, 64'h1000, 72'h0);
        cmp("none", 17'h1_000F, {alloc_none, cache_way_usable});
        mdl.send(4'h4, 1'h0, 4'h0, 64'h0, 72'h00_0123_4567_89AB_CDEF);
        w = enc_word;
        cmp("encv", 1'h1, enc_valid);
        wr(12'h040, 32'h1_0009);
        mdl.send(4'h4, 1'h0, 4'h0, 64'h0, 72'h00_0123_4567_89AB_CDEF);
        cmp("inj", w ^ 72'h200, enc_word);
        mdl.send(4'h8, 1'h0, 4'h0, 64'h1000, w ^ 72'h200);
        cmp("fix", {3'h5, 64'h0123_4567_89AB_CDEF}, {chk_valid, chk_fail, wb_valid, chk_data});
        cmp("wbword", w, wb_word);
        cmp("evt", 4'h2, evt);
        rd(12'h148);
        cmp("cnt", 32'h1, rv);
        rd(12'h140);
        cmp("addr", 32'h1000, rv);
        @(negedge aclk);
        cmp("evt", 4'h0, evt);
        mdl.send(4'h8, 1'h1, 4'h0, 64'h2000, w ^ 72'h6);
        cmp("fail", 5'h14, {chk_fail, evt});
        rd(12'h128);
        cmp("cnt", 32'h1, rv);
        @(negedge aclk);
        cmp("evt", 4'h0, evt);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        cmp("ways", 16'h0001, cache_way_usable);
        print_verdict();
    end
endmodule : l2pc_ctrl_tb_top

// ---- l2pc_err_track.sv ----
// address capture, counter and sticky event of one error class
`timescale 1ns/1ps
`include "l2pc_cfg.svh"
module l2pc_err_track (
    input wire logic aclk,
    input wire logic aresetn,
    l2pc_trk_if.trk trk
);
    l2pc_pkg::l2pc_trk_st_t st_q;
    l2pc_pkg::l2pc_trk_st_t st_d;

    // a new error in the clearing cycle keeps the event set
    always_comb begin
        st_d = st_q;
        if (trk.rd_clr) st_d.flag = 1'b0;
        if (trk.evt) begin
            st_d.addr = trk.addr;
            if (st_q.count != `L2PC_CNT_MAX) st_d.count = st_q.count + 32'h1;
            st_d.flag = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) st_q <= '0;
        else st_q <= st_d;
    end

    assign trk.cap_addr = st_q.addr;
    assign trk.count = st_q.count;
    assign trk.flag = st_q.flag;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_trk_clear;
        (trk.rd_clr && !trk.evt) |=> !trk.flag;
    endproperty
    a_trk_clear: assert property (p_trk_clear) else $error("event not cleared by read");

    property p_trk_count;
        (trk.evt && trk.count != `L2PC_CNT_MAX)
            |=> (trk.flag && trk.count == $past(trk.count) + 32'h1 && trk.cap_addr == $past(trk.addr));
    endproperty
    a_trk_count: assert property (p_trk_count) else $error("error not counted");
endmodule : l2pc_err_track

// ---- l2pc_master_model.sv ----
// cache-side master model issuing alloc, evict, encode and check requests
`timescale 1ns/1ps
module l2pc_master_model (
    input wire logic aclk,
    output logic [3:0] req,
    output logic meta,
    output logic [3:0] master,
    output logic [63:0] addr,
    output logic [71:0] data
);
    // ----
    // one-cycle request, address and data scrambled once taken
    // ----
    initial begin
        req = 4'h0;
        meta = 1'h0;
        master = 4'h0;
        addr = 64'h0;
        data = 72'h0;
    end
    task automatic send(input logic [3:0] k, input logic mt, input logic [3:0] ms,
                        input logic [63:0] a, input logic [71:0] d);
        @(posedge aclk);
        req <= k;
        meta <= mt;
        master <= ms;
        addr <= a;
        data <= d;
        @(posedge aclk);
        req <= 4'h0;
        addr <= ~a;
        data <= ~d;
        @(negedge aclk);
    endtask : send
endmodule : l2pc_master_model

// ---- l2pc_pkg.sv ----
// types of the cache power, scratch region and ecc control block
package l2pc_pkg;
    typedef enum logic [1:0] {
        L2PC_META_FIX = 2'h0,
        L2PC_META_FAIL = 2'h1,
        L2PC_DATA_FIX = 2'h2,
        L2PC_DATA_FAIL = 2'h3
    } l2pc_trk_id_t;
    typedef struct packed {
        logic [63:0] addr;
        logic [31:0] count;
        logic flag;
    } l2pc_trk_st_t;
    typedef struct packed {
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] pd;
        logic [7:0] way_lim;
        logic inj_en;
        logic [6:0] inj_bit;
        logic [14:0][15:0] mask;
        logic enc_valid;
        logic [71:0] enc_word;
        logic chk_valid;
        logic chk_fail;
        logic [63:0] chk_data;
        logic wb_valid;
        logic [63:0] wb_addr;
        logic [71:0] wb_word;
        logic alloc_valid;
        logic alloc_none;
        logic [3:0] alloc_way;
        logic alloc_cacheable;
        logic alloc_unbacked;
        logic evict_writeback;
    } l2pc_ctrl_st_t;
endpackage : l2pc_pkg

// ---- l2pc_secded.sv ----
// secded encoder and checker for 64 data bits in a 72-bit word
`timescale 1ns/1ps
`include "l2pc_cfg.svh"
module l2pc_secded (
    input wire logic [63:0] enc_data,
    output logic [71:0] enc_word,
    input wire logic [71:0] chk_word,
    output logic [71:0] chk_fixed,
    output logic [63:0] chk_data,
    output logic chk_single,
    output logic chk_double
);
    logic [71:0] place_w;
    logic [6:0] enc_s;
    logic [6:0] chk_s;

    function automatic logic [6:0] synd(input logic [71:0] w);
        logic [6:0] s;
        s = '0;
        for (int i = 1; i < `L2PC_ECC_W; i++) begin
            if (w[i]) s = s ^ 7'(i);
        end
        return s;
    endfunction : synd

    // data bits sit at the positions from 3 up that are not powers of two
    always_comb begin
        int j;
        j = 0;
        place_w = '0;
        chk_data = '0;
        for (int i = 3; i < `L2PC_ECC_W; i++) begin
            if ((i & (i - 1)) != 0) begin
                place_w[i] = enc_data[j];
                chk_data[j] = chk_fixed[i];
                j = j + 1;
            end
        end
    end

    always_comb begin
        enc_s = synd(place_w);
        enc_word = place_w;
        for (int k = 0; k < `L2PC_ECC_CHK; k++) begin
            enc_word[1 << k] = enc_s[k];
        end
        enc_word[0] = ^enc_word[71:1];
    end

    // odd overall parity with a syndrome inside the word is one bad bit
    always_comb begin
        chk_s = synd(chk_word);
        chk_single = (^chk_word) && (chk_s < 7'(`L2PC_ECC_W));
        chk_double = !chk_single && ((chk_s != '0) || (^chk_word));
        chk_fixed = chk_word;
        if (chk_single) chk_fixed[chk_s] = !chk_word[chk_s];
    end
endmodule : l2pc_secded

// ---- l2pc_trk_if.sv ----
// link between the controller and one error tracker
`timescale 1ns/1ps
interface l2pc_trk_if;
    logic evt;
    logic [63:0] addr;
    logic rd_clr;
    logic [63:0] cap_addr;
    logic [31:0] count;
    logic flag;
    modport trk (input evt, input addr, input rd_clr, output cap_addr, output count, output flag);
    modport ctl (output evt, output addr, output rd_clr, input cap_addr, input count, input flag);
endinterface : l2pc_trk_if
